// *** hdl/tdm_char_dma.sv ***
`timescale 1ns/1ns
// Functional notes
// RQ1 - software writes address bits 15..1; all 16 bits drive transfers
// RQ2 - memory address is two extended bits above the 16-bit register
// RQ3 - software loads first byte address before starting a command
// RQ4 - address increments by one right after each memory access
// RQ5 - after a record the address is one past its last character
// RQ6 - extended bits take the carry out of the 16-bit address
// RQ7 - on late grant or missing memory the address stays at failure
// RQ8 - buffer read bits 15..9 show character bits 7..1
// RQ9 - buffer bit 8 is tape parity, never written to memory
// RQ10 - nine-channel parity valid only after CRC with final select set
// RQ11 - transport makes parity; device drives even or odd polarity
// RQ12 - buffer bits 7..0 stage bytes both to and from tape
// RQ13 - final select one loads LRC; zero blocks it, keeping CRC
// RQ14 - after end-of-file buffer is zero if select set, else the mark
// RQ15 - one byte per bus cycle, alternating low and high byte lanes
// RQ16 - timer bit 15 is a 100 us square wave at half duty
// RQ17 - writing bit 13 sets ready and forces a premature gap shutdown
// RQ18 - bit 12 shows gap shutdown; bits 11..9 read zero
// RQ19 - bits 8..0 zero after good operation; a one flags a channel
// RQ20 - bits 7..0 are channels 0..7, cleared on read unless in error
// RQ21 - read strobe loads buffer, requests, then byte write to memory
// RQ22 - write strobe requests, then a read cycle fetches one byte
module tdm_char_dma #(
    parameter int unsigned TIMER_HALF_CYC = tdm_pkg::TIMER_HALF_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [1:0]        regSel,
    input  wire logic              regWr,
    input  wire logic              regRd,
    input  wire logic [15:0]       regWdata,
    output logic [15:0]            regRdata,
    input  wire logic              extLoad,
    input  wire logic [1:0]        extIn,
    output logic [1:0]             extAddr,
    input  wire logic              evenParitySel,
    input  wire logic              controllerReady,
    output logic                   readySetPulse,
    input  wire logic              nineChannel,
    input  wire tdm_pkg::tdm_tape_s tapePins,
    output logic [7:0]             tapeWdata,
    output logic                   tapeParEven,
    output logic                   forceGap,
    output logic                   badTape,
    output logic                   parityValid,
    output logic                   dmaReq,
    input  wire logic              busGrant,
    input  wire logic              busDone,
    input  wire logic              busLateGrant,
    input  wire logic              busNoMem,
    input  wire logic [15:0]       busRdata,
    output tdm_pkg::tdm_bus_s      busOut,
    output logic                   dmaErr
);

    // ****************
    // pin synchroniser, three stages
    // ****************
    tdm_pkg::tdm_tape_s s1_ff, s2_ff, s3_ff;
    logic               rdLvl_ff, wrLvl_ff;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            rdLvl_ff <= 1'b0;
            wrLvl_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= tapePins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff.readStrobe == s3_ff.readStrobe)
                rdLvl_ff <= s3_ff.readStrobe;
            if (s2_ff.writeStrobe == s3_ff.writeStrobe)
                wrLvl_ff <= s3_ff.writeStrobe;
        end
    end

    // a strobe counts once stages two and three agree on the new level
    wire        rdRise  = s2_ff.readStrobe & s3_ff.readStrobe & ~rdLvl_ff;
    wire        wrRise  = s2_ff.writeStrobe & s3_ff.writeStrobe & ~wrLvl_ff;
    wire        gapPin  = s2_ff.gapShutdown & s3_ff.gapShutdown;
    wire [8:0]  tapeChr = {s2_ff.parity, s2_ff.data};
    wire        isCrc   = s2_ff.isCrc;
    wire        isLrc   = s2_ff.isLrc;
    wire        isEof   = s2_ff.isEof;
    wire        isData  = ~(isCrc | isLrc | isEof);

    // ****************
    // registers and state
    // ****************
    tdm_pkg::tdm_state_e state_ff, nxt_state;
    logic [15:0] addr_ff;
    logic [1:0]  ext_ff;
    logic [8:0]  buf_ff;
    logic        toMem_ff;
    logic        charSel_ff;
    logic        bteArm_ff;
    logic        forcedGap_ff;
    logic        readySet_ff;
    logic        badTape_ff;
    logic        dmaErr_ff;
    logic        crcSeen_ff;
    logic        lrcSeen_ff;
    logic [8:0]  lineAcc_ff;
    logic [15:0] rdata_ff;
    logic [15:0] busWdata_ff;
    logic [7:0]  tapeW_ff;
    logic        timerBit;

    tdm_timer #(
        .HALF_CYC (TIMER_HALF_CYC)
    ) u_timer (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .timerBit (timerBit)
    );

    // ****************
    // decode
    // ****************
    wire         idle      = (state_ff == tdm_pkg::ST_IDLE);
    wire         inReq     = (state_ff == tdm_pkg::ST_REQ);
    wire         inBus     = (state_ff == tdm_pkg::ST_BUS);
    wire         wrAddr    = regWr && (regSel == tdm_pkg::SEL_ADDR);
    wire         wrLines   = regWr && (regSel == tdm_pkg::SEL_LINES);
    wire         rdLines   = regRd && (regSel == tdm_pkg::SEL_LINES);
    wire         accessOk  = inBus && busDone && !busNoMem;
    wire         accessBad = (inReq && busLateGrant) || (inBus && busNoMem);
    wire [17:0]  fullAddr  = {ext_ff, addr_ff};
    wire [17:0]  incAddr   = fullAddr + 18'h00001;
    wire         gapActive = gapPin | forcedGap_ff;
    wire         rdLoad    = idle && rdRise;
    wire         loadBuf   = rdLoad && !(isLrc && !charSel_ff);
    wire [8:0]   loadVal   = (isEof && charSel_ff) ? 9'h000 : tapeChr;
    wire [7:0]   fetched   = addr_ff[0] ? busRdata[15:8] : busRdata[7:0];
    wire         lineErr   = lrcSeen_ff && (lineAcc_ff != 9'h000);
    wire [15:0]  lineWord  = {timerBit, charSel_ff, 1'b0, gapActive, 3'b000, lineAcc_ff};
    wire [15:0]  bufWord   = {buf_ff[7:1], buf_ff[tdm_pkg::BUF_PAR], buf_ff[7:0]};

    // ****************
    // transfer sequencer
    // ****************
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            tdm_pkg::ST_IDLE:
            begin
                if ((rdRise && isData) || wrRise)
                    nxt_state = tdm_pkg::ST_REQ; // RQ21 RQ22
            end
            tdm_pkg::ST_REQ:
            begin
                if (busLateGrant)
                    nxt_state = tdm_pkg::ST_IDLE;
                else if (busGrant)
                    nxt_state = tdm_pkg::ST_BUS;
            end
            tdm_pkg::ST_BUS:
            begin
                if (busDone || busNoMem)
                    nxt_state = tdm_pkg::ST_IDLE;
            end
            default:
                nxt_state = tdm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= tdm_pkg::ST_IDLE;
            toMem_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (idle && (rdRise || wrRise))
                toMem_ff <= rdRise;
        end
    end

    // ****************
    // transfer address with extended bits
    // ****************
    // each software load wins over the increment of its own bits in the same cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_ff <= tdm_pkg::ADDR_RST;
            ext_ff  <= tdm_pkg::EXT_RST;
        end
        else
        begin
            if (wrAddr)
                addr_ff[15:1] <= regWdata[15:1]; // RQ1
            else if (accessOk)
                addr_ff <= incAddr[15:0]; // RQ4 RQ5
            if (extLoad)
                ext_ff <= extIn;
            else if (accessOk)
                ext_ff <= incAddr[17:16]; // RQ6
        end
    end

    // ****************
    // character buffer
    // ****************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            buf_ff      <= tdm_pkg::BUF_RST;
            busWdata_ff <= 16'h0000;
            tapeW_ff    <= 8'h00;
            crcSeen_ff  <= 1'b0;
        end
        else
        begin
            if (loadBuf)
            begin
                buf_ff      <= loadVal; // RQ12 RQ13 RQ14
                busWdata_ff <= {loadVal[7:0], loadVal[7:0]}; // RQ9
            end
            else if (accessOk && !toMem_ff)
            begin
                buf_ff[7:0] <= fetched; // RQ12 RQ15
                tapeW_ff    <= fetched;
            end
            if (rdLoad)
                crcSeen_ff <= isCrc;
        end
    end

    // ****************
    // read lines: gap, bad tape, longitudinal check
    // ****************
    // the forced gap lasts until the next command drops ready
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            charSel_ff   <= tdm_pkg::CHSEL_RST;
            bteArm_ff    <= 1'b0;
            forcedGap_ff <= 1'b0;
            readySet_ff  <= 1'b0;
            badTape_ff   <= 1'b0;
            dmaErr_ff    <= 1'b0;
        end
        else
        begin
            readySet_ff <= wrLines && regWdata[tdm_pkg::LN_BTE]; // RQ17
            badTape_ff  <= rdRise && gapActive;
            dmaErr_ff   <= accessBad; // RQ7
            if (wrLines)
                charSel_ff <= regWdata[tdm_pkg::LN_CHSEL];
            if (wrLines && regWdata[tdm_pkg::LN_BTE])
                bteArm_ff <= 1'b1;
            else if (forcedGap_ff && !controllerReady)
                bteArm_ff <= 1'b0;
            if (bteArm_ff && controllerReady)
                forcedGap_ff <= 1'b1; // RQ17
            else if (!controllerReady)
                forcedGap_ff <= 1'b0;
        end
    end

    // a fresh character wins over a clear by a read in the same cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            lineAcc_ff <= 9'h000;
            lrcSeen_ff <= 1'b0;
        end
        else
        begin
            if (rdLoad)
            begin
                lineAcc_ff <= lineAcc_ff ^ tapeChr; // RQ19 RQ20
                lrcSeen_ff <= isLrc | lrcSeen_ff;
            end
            else if (rdLines && !lineErr)
            begin
                lineAcc_ff <= 9'h000; // RQ20
                lrcSeen_ff <= 1'b0;
            end
        end
    end

    // ****************
    // processor read port
    // ****************
    wire [15:0] rdMux = (regSel == tdm_pkg::SEL_ADDR)  ? {addr_ff[15:1], 1'b0} :
                        (regSel == tdm_pkg::SEL_BUF)   ? bufWord : // RQ8 RQ9
                        (regSel == tdm_pkg::SEL_LINES) ? lineWord : // RQ16 RQ18
                        16'h0000;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rdata_ff <= 16'h0000;
        else if (regRd)
            rdata_ff <= rdMux;
    end

    // ****************
    // outputs
    // ****************
    assign regRdata       = rdata_ff;
    assign extAddr        = ext_ff;
    assign readySetPulse  = readySet_ff;
    assign tapeWdata      = tapeW_ff;
    assign tapeParEven    = evenParitySel; // RQ11
    assign forceGap       = forcedGap_ff;
    assign badTape        = badTape_ff;
    assign parityValid    = nineChannel && crcSeen_ff && charSel_ff; // RQ10
    assign dmaReq         = inReq;
    assign dmaErr         = dmaErr_ff;
    assign busOut.addr      = fullAddr; // RQ2
    assign busOut.wdata     = busWdata_ff;
    assign busOut.byteWrite = inBus && toMem_ff;
    assign busOut.wordRead  = inBus && !toMem_ff;

    // ****************
    // checks
    // ****************
    logic [15:0] sinceFlip_ff;
    logic        timerLast_ff;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sinceFlip_ff <= 16'h0000;
            timerLast_ff <= 1'b0;
        end
        else
        begin
            timerLast_ff <= timerBit;
            sinceFlip_ff <= (timerBit != timerLast_ff) ? 16'h0001 : sinceFlip_ff + 16'h0001;
        end
    end

    property p_inc;
        @(posedge sys_clk) disable iff (rst)
        (accessOk && !wrAddr && !extLoad) |=> (fullAddr == $past(incAddr));
    endproperty
    a_inc: assert property (p_inc) else $error("address not advanced by one"); // RQ4

    property p_carry;
        @(posedge sys_clk) disable iff (rst)
        (accessOk && addr_ff == 16'hffff && !wrAddr && !extLoad)
            |=> (addr_ff == 16'h0000) && (ext_ff == $past(ext_ff) + 2'h1);
    endproperty
    a_carry: assert property (p_carry) else $error("carry missed extended bits"); // RQ6

    property p_errHold;
        @(posedge sys_clk) disable iff (rst)
        (accessBad && !wrAddr && !extLoad) |=> $stable(fullAddr) && dmaErr;
    endproperty
    a_errHold: assert property (p_errHold) else $error("address moved on error"); // RQ7

    property p_lane;
        @(posedge sys_clk) disable iff (rst)
        busOut.byteWrite |-> (busOut.wdata[7:0] == buf_ff[7:0]) && (busOut.wdata[15:8] == buf_ff[7:0]);
    endproperty
    a_lane: assert property (p_lane) else $error("byte lane data wrong"); // RQ15

    property p_request;
        @(posedge sys_clk) disable iff (rst)
        (idle && rdRise && isData) |=> dmaReq ##0 busOut.addr == $past(fullAddr);
    endproperty
    a_request: assert property (p_request) else $error("read strobe gave no request"); // RQ21

    property p_fetch;
        @(posedge sys_clk) disable iff (rst)
        (busOut.wordRead && busDone && !busNoMem)
            |=> (tapeWdata == ($past(fullAddr[0]) ? $past(busRdata[15:8]) : $past(busRdata[7:0])));
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetched byte not staged"); // RQ22

    property p_lrcBlock;
        @(posedge sys_clk) disable iff (rst)
        (rdLoad && isLrc && !charSel_ff) |=> $stable(buf_ff);
    endproperty
    a_lrcBlock: assert property (p_lrcBlock) else $error("blocked LRC entered buffer"); // RQ13

    property p_eofZero;
        @(posedge sys_clk) disable iff (rst)
        (rdLoad && isEof && charSel_ff) |=> (buf_ff == 9'h000);
    endproperty
    a_eofZero: assert property (p_eofZero) else $error("end-of-file not zeroed"); // RQ14

    property p_timer;
        @(posedge sys_clk) disable iff (rst)
        (timerBit != timerLast_ff) |-> (sinceFlip_ff == 16'(TIMER_HALF_CYC));
    endproperty
    a_timer: assert property (p_timer) else $error("timer half period wrong"); // RQ16

    property p_clear;
        @(posedge sys_clk) disable iff (rst)
        (rdLines && !lineErr && !rdLoad) |=> (lineAcc_ff == 9'h000);
    endproperty
    a_clear: assert property (p_clear) else $error("read lines not cleared"); // RQ20

    property p_bte;
        @(posedge sys_clk) disable iff (rst)
        (wrLines && regWdata[tdm_pkg::LN_BTE]) |=> readySetPulse ##1 (!controllerReady || forceGap);
    endproperty
    a_bte: assert property (p_bte) else $error("bad tape forcer inactive"); // RQ17

    c_readXfer:  cover property (@(posedge sys_clk) disable iff (rst) busOut.byteWrite && busDone);
    c_writeXfer: cover property (@(posedge sys_clk) disable iff (rst) busOut.wordRead && busDone);
    c_error:     cover property (@(posedge sys_clk) disable iff (rst) accessBad);
    c_carry:     cover property (@(posedge sys_clk) disable iff (rst) accessOk && addr_ff == 16'hffff);

endmodule : tdm_char_dma

// *** hdl/tdm_pkg.sv ***
package tdm_pkg;

    // ****************
    // register selects on the processor port
    // ****************
    localparam logic [1:0] SEL_ADDR  = 2'h0;
    localparam logic [1:0] SEL_BUF   = 2'h1;
    localparam logic [1:0] SEL_LINES = 2'h2;

    // ****************
    // read-line and buffer register fields
    // ****************
    localparam int LN_TIMER  = 15;
    localparam int LN_CHSEL  = 14;
    localparam int LN_BTE    = 13;
    localparam int LN_GAP    = 12;
    localparam int LN_PAR    = 8;
    localparam int BUF_PAR   = 8;
    localparam int BUF_HI_LO = 9;

    // ****************
    // reset values
    // ****************
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [1:0]  EXT_RST  = 2'h0;
    localparam logic [8:0]  BUF_RST  = 9'h000;
    localparam logic        CHSEL_RST = 1'b0;

    // ****************
    // timing
    // ****************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TIMER_PERIOD_US = 100;
    localparam int TIMER_HALF_CYC  = (TIMER_PERIOD_US * 1000 / 2) / CLK_PERIOD_NS;

    // ****************
    // types
    // ****************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ  = 3'b010,
        ST_BUS  = 3'b100
    } tdm_state_e;

    typedef struct packed {
        logic       gapShutdown;
        logic       readStrobe;
        logic       writeStrobe;
        logic       isCrc;
        logic       isLrc;
        logic       isEof;
        logic       parity;
        logic [7:0] data;
    } tdm_tape_s;

    typedef struct packed {
        logic [17:0] addr;
        logic [15:0] wdata;
        logic        byteWrite;
        logic        wordRead;
    } tdm_bus_s;

endpackage : tdm_pkg

// *** hdl/tdm_timer.sv ***
`timescale 1ns/1ns
module tdm_timer #(
    parameter int unsigned HALF_CYC = 5000
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    output logic      timerBit
);

    // ****************************************
    // square wave, one flip per half period
    // ****************************************
    logic [15:0] cnt_ff;
    logic        timer_ff;
    wire         wrap = (cnt_ff == 16'(HALF_CYC - 1));

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff   <= 16'h0000;
            timer_ff <= 1'b0;
        end
        else if (wrap)
        begin
            cnt_ff   <= 16'h0000;
            timer_ff <= ~timer_ff;
        end
        else
        begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    assign timerBit = timer_ff;

endmodule : tdm_timer

// *** tb/tdm_bus_model.sv ***
`timescale 1ns/1ns
// ****************************************
// memory side of the host bus
// ****************************************
module tdm_bus_model (
    input  wire logic              sys_clk,
    input  wire logic              dmaReq,
    input  wire tdm_pkg::tdm_bus_s busOut,
    input  wire logic [1:0]        mode,
    input  wire logic              slow,
    output logic                   busGrant,
    output logic                   busDone,
    output logic                   busLateGrant,
    output logic                   busNoMem,
    output logic [15:0]            busRdata
);
    int waitCnt = 0;
    initial
    begin
        {busGrant, busDone, busLateGrant, busNoMem, busRdata} = '0;
    end
    // one-cycle answers; idle data toggles
    always @(negedge sys_clk)
    begin
        busGrant     <= 1'b0;
        busDone      <= 1'b0;
        busLateGrant <= 1'b0;
        busNoMem     <= 1'b0;
        busRdata     <= ~busRdata;
        if (!(dmaReq || busOut.byteWrite || busOut.wordRead) || busGrant || busDone || busLateGrant || busNoMem)
            waitCnt <= 0;
        else if (waitCnt < (slow ? 5 : 0))
            waitCnt <= waitCnt + 1;
        else if (dmaReq)
        begin
            busGrant     <= (mode != 2'h2);
            busLateGrant <= (mode == 2'h2);
        end
        else
        begin
            busDone  <= (mode != 2'h1);
            busNoMem <= (mode == 2'h1);
            busRdata <= {~busOut.addr[7:0], busOut.addr[7:0]};
        end
    end
endmodule : tdm_bus_model

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic [1:0]         regSel, extIn, extAddr, mode;
    logic               regWr, regRd, extLoad, evenParitySel, controllerReady, nineChannel, slow;
    logic [15:0]        regWdata, regRdata, busRdata;
    tdm_pkg::tdm_tape_s tapePins;
    tdm_pkg::tdm_bus_s  busOut;
    logic [7:0]         tapeWdata;
    logic               readySetPulse, tapeParEven, forceGap, badTape, parityValid, dmaReq;
    logic               busGrant, busDone, busLateGrant, busNoMem, dmaErr, rdLast;
    logic [31:0]        expRd[$];
    logic [25:0]        expWr[$];
    logic [31:0]        e;
    logic [17:0]        expAddr;
    logic [8:0]         c1, c2, c3;
    int                 n_mismatch = 0, checks = 0, nDone = 0, nErr = 0, nReady = 0, nBad = 0;
    int                 seed = 40154, ones, err0;

    tdm_char_dma #(.TIMER_HALF_CYC(8)) i_tdm_char_dma (.sys_clk(sys_clk), .rst(rst), .regSel(regSel),
        .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .extLoad(extLoad),
        .extIn(extIn), .extAddr(extAddr), .evenParitySel(evenParitySel), .controllerReady(controllerReady),
        .readySetPulse(readySetPulse), .nineChannel(nineChannel), .tapePins(tapePins),
        .tapeWdata(tapeWdata), .tapeParEven(tapeParEven), .forceGap(forceGap), .badTape(badTape),
        .parityValid(parityValid), .dmaReq(dmaReq), .busGrant(busGrant), .busDone(busDone),
        .busLateGrant(busLateGrant), .busNoMem(busNoMem), .busRdata(busRdata), .busOut(busOut),
        .dmaErr(dmaErr));
    tdm_bus_model i_tdm_bus_model (.sys_clk(sys_clk), .dmaReq(dmaReq), .busOut(busOut), .mode(mode),
        .slow(slow), .busGrant(busGrant), .busDone(busDone), .busLateGrant(busLateGrant),
        .busNoMem(busNoMem), .busRdata(busRdata));

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("mismatches %0d, comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic reg_wr(input logic [1:0] sel, input logic [15:0] d);
        @(negedge sys_clk);
        regSel = sel;
        regWdata = d;
        regWr = 1'b1;
        @(negedge sys_clk);
        regWr = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [1:0] sel, input logic [15:0] mask, input logic [15:0] val);
        @(negedge sys_clk);
        expRd.push_back({mask, val & mask});
        regSel = sel;
        regRd = 1'b1;
        @(negedge sys_clk);
        regRd = 1'b0;
    endtask : reg_rd

    // data reads note the memory byte; bounded wait
    task automatic tape(input logic [2:0] kind, input logic [8:0] ch, input logic wr, input logic expMem);
        int n0;
        n0 = nDone;
        if (expMem)
        begin
            expWr.push_back({expAddr, ch[7:0]});
            expAddr++;
        end
        @(negedge sys_clk);
        {tapePins.isCrc, tapePins.isLrc, tapePins.isEof, tapePins.parity, tapePins.data} = {kind, ch};
        @(negedge sys_clk);
        tapePins.readStrobe = !wr;
        tapePins.writeStrobe = wr;
        repeat (5) @(negedge sys_clk);
        tapePins.readStrobe = 1'b0;
        tapePins.writeStrobe = 1'b0;
        for (int i = 0; i < 40 && kind == 3'h0 && nDone == n0; i++)
            @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
    endtask : tape

    // ****************
    // result watcher
    // ****************
    always @(posedge sys_clk)
    begin
        rdLast <= regRd;
        nDone <= nDone + int'(busDone | busNoMem | busLateGrant);
        nErr <= nErr + int'(dmaErr);
        nReady <= nReady + int'(readySetPulse);
        nBad <= nBad + int'(badTape);
        if (rdLast)
        begin
            e = (expRd.size() > 0) ? expRd.pop_front() : 32'hffff_0bad;
            check({16'h0, regRdata & e[31:16]}, {16'h0, e[15:0]});
        end
        if (busDone && busOut.byteWrite && expWr.size() > 0)
            check({busOut.addr, busOut.addr[0] ? busOut.wdata[15:8] : busOut.wdata[7:0]}, expWr.pop_front());
    end

    initial
    begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end

    // ****************
    // scenarios
    // ****************
    initial
    begin
        {regSel, extIn, mode, regWr, regRd, extLoad, evenParitySel, controllerReady, nineChannel, slow} = '0;
        regWdata = 16'h0000;
        tapePins = '0;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        for (int p = 0; p < 2; p++)
        begin
            @(negedge sys_clk);
            evenParitySel = p[0];
            #1 check({31'h0, tapeParEven}, p);
        end
        reg_rd(tdm_pkg::SEL_ADDR, 16'hffff, 16'h0000);
        reg_rd(tdm_pkg::SEL_BUF, 16'hffff, 16'h0000);
        reg_rd(tdm_pkg::SEL_LINES, 16'h7fff, 16'h0000);
        reg_rd(2'h3, 16'hffff, 16'h0000);
        regWdata = $random(seed);
        reg_wr(tdm_pkg::SEL_ADDR, regWdata);
        reg_rd(tdm_pkg::SEL_ADDR, 16'hffff, regWdata & 16'hfffe);
        // carry into extended bits
        @(negedge sys_clk);
        extIn = 2'h1;
        extLoad = 1'b1;
        @(negedge sys_clk);
        extLoad = 1'b0;
        reg_wr(tdm_pkg::SEL_ADDR, 16'hfffe);
        expAddr = 18'h1fffe;
        c1 = $random(seed);
        c2 = $random(seed);
        c3 = $random(seed);
        tape(3'h0, c1, 1'b0, 1'b1);
        tape(3'h0, c2, 1'b0, 1'b1);
        tape(3'h0, c3, 1'b0, 1'b1);
        check({30'h0, extAddr}, 32'h2);
        reg_rd(tdm_pkg::SEL_ADDR, 16'hffff, 16'h0000);
        reg_rd(tdm_pkg::SEL_BUF, 16'hffff, {c3[7:1], c3[8], c3[7:0]});
        reg_wr(tdm_pkg::SEL_BUF, 16'h5a5a);
        reg_rd(tdm_pkg::SEL_BUF, 16'hffff, {c3[7:1], c3[8], c3[7:0]});
        reg_rd(tdm_pkg::SEL_LINES, 16'h7fff, {7'h0, c1 ^ c2 ^ c3});
        reg_rd(tdm_pkg::SEL_LINES, 16'h7fff, 16'h0000);
        // record ends, both selects
        nineChannel = 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            reg_wr(tdm_pkg::SEL_LINES, 16'(s) << 14);
            c1 = $random(seed);
            c2 = $random(seed);
            c3 = $random(seed);
            tape(3'h0, c1, 1'b0, 1'b1);
            tape(3'h4, c2, 1'b0, 1'b0);
            check({31'h0, parityValid}, s);
            tape(3'h2, c1 ^ c2, 1'b0, 1'b0);
            reg_rd(tdm_pkg::SEL_BUF, 16'h00ff, s ? 16'(c1[7:0] ^ c2[7:0]) : 16'(c2[7:0]));
            reg_rd(tdm_pkg::SEL_LINES, 16'h7fff, 16'(s) << 14);
            tape(3'h1, c3, 1'b0, 1'b0);
            reg_rd(tdm_pkg::SEL_BUF, 16'h00ff, s ? 16'h0000 : 16'(c3[7:0]));
            reg_rd(tdm_pkg::SEL_LINES, 16'h7fff, (16'(s) << 14) | 16'(c3));
        end
        // slow fetches, lane by bit 0
        slow = 1'b1;
        reg_wr(tdm_pkg::SEL_ADDR, 16'h0040);
        expAddr[15:1] = 15'h0020;
        for (int i = 0; i < 2 || !expAddr[0]; i++)
        begin
            tape(3'h0, 9'h000, 1'b1, 1'b0);
            check({24'h0, tapeWdata}, {24'h0, expAddr[0] ? ~expAddr[7:0] : expAddr[7:0]});
            expAddr++;
        end
        slow = 1'b0;
        for (int m = 1; m < 3; m++)
        begin
            mode = m[1:0];
            err0 = nErr;
            tape(3'h0, 9'h0a5, 1'b0, 1'b0);
            check(nErr - err0, 1);
            reg_rd(tdm_pkg::SEL_ADDR, 16'hffff, expAddr[15:0] & 16'hfffe);
        end
        mode = 2'h0;
        // forced gap
        controllerReady = 1'b1;
        reg_wr(tdm_pkg::SEL_LINES, 16'h2000);
        repeat (2) @(negedge sys_clk);
        check(nReady, 1);
        check({31'h0, forceGap}, 1);
        tape(3'h0, 9'h011, 1'b0, 1'b0);
        check(32'(nBad > 0), 1);
        controllerReady = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({31'h0, forceGap}, 0);
        tapePins.gapShutdown = 1'b1;
        repeat (5) @(negedge sys_clk);
        reg_rd(tdm_pkg::SEL_LINES, 16'h3e00, 16'h1000);
        // timer, half cycle 8
        ones = 0;
        @(negedge sys_clk);
        regRd = 1'b1;
        repeat (32)
        begin
            expRd.push_back(32'h0);
            @(negedge sys_clk);
            ones += int'(regRdata[15]);
        end
        regRd = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(ones, 16);
        check(expRd.size() + expWr.size(), 0);
        report_and_stop();
    end
endmodule : testbench
